// ---- hdl/ssir_pkg.sv ----
package ssir_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h00;
    localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h04;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h08;
    localparam logic [7:0] OFS_POWER_CLOCK_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CRYSTAL_OSC_CTRL = 8'h10;
    localparam logic [7:0] OFS_CRYSTAL_32K_CTRL = 8'h14;
    localparam logic [7:0] OFS_INTERNAL_32K_CTRL = 8'h18;
    localparam logic [7:0] OFS_ULTRALOW_32K_CTRL = 8'h1C;
    localparam logic [7:0] OFS_INTERNAL_8M_CTRL = 8'h20;
    localparam logic [7:0] OFS_FLL_CONTROL = 8'h24;
    localparam logic [7:0] OFS_FLL_VALUE = 8'h28;
    localparam logic [7:0] OFS_FLL_MULTIPLIER = 8'h2C;
    localparam logic [7:0] OFS_FLL_SYNC_REQUEST = 8'h30;
    localparam logic [7:0] OFS_IO_BROWNOUT_CONTROL = 8'h34;
    localparam logic [7:0] OFS_CORE_BROWNOUT_CONTROL = 8'h38;

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int IRQ_W = 18;
    localparam int BIT_LOOP_READY = 4;
    localparam int BIT_IO_BOD_SYNC_READY = 11;
    localparam int BIT_CORE_BOD_SYNC_READY = 14;
    localparam int BIT_FLL_ENABLE = 1;
    localparam int BIT_READ_REQUEST = 7;
    localparam logic [IRQ_W-1:0] IRQ_IMPL_MASK = 18'h3CFFF;
    localparam logic [IRQ_W-1:0] STATUS_INTERNAL_MASK = 18'h04810;
    localparam logic [IRQ_W-1:0] STATUS_RST = 18'h04810;
    localparam logic [15:0] MASK16 = 16'hFFFF;
    localparam logic [7:0] MASK8 = 8'hFF;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam int SYNC_CYCLES_DEF = 6;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] crystal_osc;
        logic [15:0] crystal_32k;
        logic [31:0] internal_32k;
        logic [7:0] ultralow_32k;
        logic [31:0] internal_8m;
    } ssir_osc_cfg_t;

    typedef struct packed {
        logic [15:0] control;
        logic [31:0] value;
        logic [31:0] multiplier;
    } ssir_fll_cfg_t;

    typedef struct packed {
        logic [31:0] io_ctrl;
        logic [31:0] core_ctrl;
    } ssir_bod_cfg_t;

endpackage

// ---- hdl/ssir_sync_timer.sv ----
`timescale 1ns/1ps
module ssir_sync_timer #(
    parameter int CYCLES = 6
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // ----------------------------------------------------------------
    // crossing latency model: busy for CYCLES clocks, done on the last
    // ----------------------------------------------------------------
    assign o_busy = (cnt_q != '0);
    assign o_done = (cnt_q == ONE);
    assign cnt_d = i_start ? LOAD : (o_busy ? cnt_q - ONE : cnt_q);

    // counter; a start while busy restarts the window
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// ---- hdl/ssir_top.sv ----
// Functional notes
// - all enabled requests ORed into one line
// - loop writes ignored while loop ready low
// - loop ready rising edge raises its interrupt
// - read request bit starts loop read sync
// - unrequested loop read starts sync, stalls bus
// - disabled loop reads complete without stalling
// - brown-out accesses pass a delayed synchronizer
// - brown-out write clears then sets sync ready
// - brown-out write during sync stalls the bus
// - read of busy brown-out register stalls
// - stalled access completes after earlier sync
// - sync ready visible in status and interrupt
// - request held while flag and enable set
// - enable set and clear registers, write one
`timescale 1ns/1ps
module ssir_top #(
    parameter int SYNC_CYCLES = ssir_pkg::SYNC_CYCLES_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [ssir_pkg::IRQ_W-1:0] i_raw_status,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    output logic o_irq,
    output ssir_pkg::ssir_osc_cfg_t o_osc_cfg,
    output ssir_pkg::ssir_fll_cfg_t o_fll_cfg,
    output ssir_pkg::ssir_bod_cfg_t o_bod_cfg
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } ssir_state_t;

    // ----------------------------------------------------------------
    // reset release and status synchronisers
    // ----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;
    logic [ssir_pkg::IRQ_W-1:0] stat_meta_q;
    logic [ssir_pkg::IRQ_W-1:0] stat_sync_q;

    // assert asynchronously, release on the clock
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // analog ready bits arrive from other domains: two flops first
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_meta_q <= '0;
            stat_sync_q <= '0;
        end else begin
            stat_meta_q <= i_raw_status;
            stat_sync_q <= stat_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    ssir_state_t state_q;
    ssir_state_t state_d;
    ssir_pkg::ssir_osc_cfg_t osc_q;
    ssir_pkg::ssir_fll_cfg_t fll_q;
    ssir_pkg::ssir_bod_cfg_t bod_q;
    logic [ssir_pkg::IRQ_W-1:0] en_q;
    logic [ssir_pkg::IRQ_W-1:0] en_d;
    logic [ssir_pkg::IRQ_W-1:0] flag_q;
    logic [ssir_pkg::IRQ_W-1:0] flag_d;
    logic [ssir_pkg::IRQ_W-1:0] stat_prev_q;
    logic [ssir_pkg::IRQ_W-1:0] status_now;
    logic [ssir_pkg::IRQ_W-1:0] rise;
    logic rd_valid_q;
    logic rd_valid_d;
    logic irq_d;
    logic pready_d;
    logic pslverr_d;
    logic [31:0] prdata_d;

    // ----------------------------------------------------------------
    // synchronisation timers for the loop and both brown-out detectors
    // ----------------------------------------------------------------
    logic fll_start;
    logic fll_busy;
    logic fll_done;
    logic io_start;
    logic io_busy;
    logic io_done;
    logic core_start;
    logic core_busy;
    logic core_done;

    ssir_sync_timer #(.CYCLES(SYNC_CYCLES)) u_fll_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_start(fll_start),
        .o_busy(fll_busy),
        .o_done(fll_done)
    );

    ssir_sync_timer #(.CYCLES(SYNC_CYCLES)) u_io_bod_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_start(io_start),
        .o_busy(io_busy),
        .o_done(io_done)
    );

    ssir_sync_timer #(.CYCLES(SYNC_CYCLES)) u_core_bod_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_start(core_start),
        .o_busy(core_busy),
        .o_done(core_done)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire acc = i_psel & i_penable;
    wire st_idle = (state_q == ST_IDLE);
    wire st_wait = (state_q == ST_WAIT);
    wire wr = i_pwrite;
    wire a_enclr = (i_paddr == ssir_pkg::OFS_IRQ_ENABLE_CLEAR);
    wire a_enset = (i_paddr == ssir_pkg::OFS_IRQ_ENABLE_SET);
    wire a_flags = (i_paddr == ssir_pkg::OFS_IRQ_FLAGS);
    wire a_stat = (i_paddr == ssir_pkg::OFS_POWER_CLOCK_STATUS);
    wire a_crystal_osc_ctrl = (i_paddr == ssir_pkg::OFS_CRYSTAL_OSC_CTRL);
    wire a_x32k = (i_paddr == ssir_pkg::OFS_CRYSTAL_32K_CTRL);
    wire a_i32k = (i_paddr == ssir_pkg::OFS_INTERNAL_32K_CTRL);
    wire a_ulp = (i_paddr == ssir_pkg::OFS_ULTRALOW_32K_CTRL);
    wire a_i8m = (i_paddr == ssir_pkg::OFS_INTERNAL_8M_CTRL);
    wire a_fctl = (i_paddr == ssir_pkg::OFS_FLL_CONTROL);
    wire a_fval = (i_paddr == ssir_pkg::OFS_FLL_VALUE);
    wire a_fmul = (i_paddr == ssir_pkg::OFS_FLL_MULTIPLIER);
    wire a_fsync = (i_paddr == ssir_pkg::OFS_FLL_SYNC_REQUEST);
    wire a_bio = (i_paddr == ssir_pkg::OFS_IO_BROWNOUT_CONTROL);
    wire a_bcore = (i_paddr == ssir_pkg::OFS_CORE_BROWNOUT_CONTROL);
    wire a_fll = a_fctl | a_fval | a_fmul;
    wire a_bod = a_bio | a_bcore;
    wire a_osc = a_crystal_osc_ctrl | a_x32k | a_i32k | a_ulp | a_i8m;
    wire mapped = a_enclr | a_enset | a_flags | a_stat | a_osc | a_fll | a_fsync | a_bod;

    // ----------------------------------------------------------------
    // stall decisions
    // ----------------------------------------------------------------
    wire loop_ready = ~fll_busy;
    wire fll_on = fll_q.control[ssir_pkg::BIT_FLL_ENABLE];
    wire bod_any_busy = io_busy | core_busy;
    wire bod_sel_busy = a_bio ? io_busy : core_busy;
    // a loop read with nothing requested must wait; disabled loop never waits
    wire s_fll_rd = a_fll & ~wr & fll_on & ~rd_valid_q;
    // any brown-out write waits out every ongoing brown-out sync
    wire s_bod_wr = a_bod & wr & bod_any_busy;
    // brown-out reads always take a sync; wait until the selected one ends
    wire s_bod_rd = a_bod & ~wr & (st_idle | bod_sel_busy);
    wire stall = s_fll_rd | s_bod_wr | s_bod_rd;
    wire commit = acc & (st_idle | st_wait) & ~stall;
    wire wcom = commit & wr;

    // loop write accepted only with loop ready high; else dropped silently
    wire fll_wr_ok = wcom & a_fll & loop_ready;
    wire rdreq = wcom & a_fsync & i_pwdata[ssir_pkg::BIT_READ_REQUEST];

    // ----------------------------------------------------------------
    // synchronisation starts
    // ----------------------------------------------------------------
    // write, explicit read request, or unrequested read all start a sync
    assign fll_start = fll_wr_ok | (rdreq & loop_ready)
        | (acc & s_fll_rd & ~fll_busy);
    // brown-out write or read kicks its detector's synchroniser
    assign io_start = (wcom & a_bio) | (acc & st_idle & a_bio & ~wr & ~io_busy);
    assign core_start = (wcom & a_bcore) | (acc & st_idle & a_bcore & ~wr & ~core_busy);

    // read data is valid once a loop sync completes; a write voids it
    assign rd_valid_d = fll_done ? 1'b1 : (fll_wr_ok ? 1'b0 : rd_valid_q);

    // ----------------------------------------------------------------
    // status and interrupt flags
    // ----------------------------------------------------------------
    // sync-ready bits low while their synchroniser runs
    assign status_now = (stat_sync_q & ~ssir_pkg::STATUS_INTERNAL_MASK)
        | ({ssir_pkg::IRQ_W{1'b0}} | ({{(ssir_pkg::IRQ_W-1){1'b0}}, loop_ready}
            << ssir_pkg::BIT_LOOP_READY))
        | ({{(ssir_pkg::IRQ_W-1){1'b0}}, ~io_busy} << ssir_pkg::BIT_IO_BOD_SYNC_READY)
        | ({{(ssir_pkg::IRQ_W-1){1'b0}}, ~core_busy} << ssir_pkg::BIT_CORE_BOD_SYNC_READY);
    // zero-to-one transitions only
    assign rise = status_now & ~stat_prev_q & ssir_pkg::IRQ_IMPL_MASK;

    function automatic logic [ssir_pkg::IRQ_W-1:0] wbits(input logic [31:0] d);
        wbits = d[ssir_pkg::IRQ_W-1:0] & ssir_pkg::IRQ_IMPL_MASK;
    endfunction

    // write one clears; a rise in the same cycle wins over the clear
    assign flag_d = (flag_q & ~((wcom & a_flags) ? wbits(i_pwdata) : '0)) | rise;
    // write one sets or clears enables; zeros leave them alone
    assign en_d = (en_q | ((wcom & a_enset) ? wbits(i_pwdata) : '0))
        & ~((wcom & a_enclr) ? wbits(i_pwdata) : '0);
    // single combined request, level while any flag and enable pair holds
    assign irq_d = |(flag_d & en_d);

    // ----------------------------------------------------------------
    // read mux and bus answer
    // ----------------------------------------------------------------
    function automatic logic [31:0] zx(input logic [ssir_pkg::IRQ_W-1:0] v);
        zx = {{(32-ssir_pkg::IRQ_W){1'b0}}, v};
    endfunction

    logic [31:0] rmux;
    assign rmux = (a_enclr | a_enset) ? zx(en_q)
        : a_flags ? zx(flag_q)
        : a_stat ? zx(status_now)
        : a_crystal_osc_ctrl ? {16'h0000, osc_q.crystal_osc}
        : a_x32k ? {16'h0000, osc_q.crystal_32k}
        : a_i32k ? osc_q.internal_32k
        : a_ulp ? {24'h000000, osc_q.ultralow_32k}
        : a_i8m ? osc_q.internal_8m
        : a_fctl ? {16'h0000, fll_q.control}
        : a_fval ? fll_q.value
        : a_fmul ? fll_q.multiplier
        : a_bio ? bod_q.io_ctrl
        : a_bcore ? bod_q.core_ctrl
        : 32'h00000000; // write-only sync request and holes read zero

    assign pready_d = commit;
    assign pslverr_d = commit & ~mapped;
    assign prdata_d = (commit & ~wr) ? rmux : 32'h00000000;

    // access sequencing: wait holds pready low, done lets penable drop
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (acc) begin
                    state_d = stall ? ST_WAIT : ST_DONE;
                end
            end
            ST_WAIT: begin
                if (commit) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    // bus side flops; the bus answer and o_irq leave from these
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h00000000;
            o_irq <= 1'b0;
        end else begin
            state_q <= state_d;
            o_pready <= pready_d;
            o_pslverr <= pslverr_d;
            o_prdata <= prdata_d;
            o_irq <= irq_d;
        end
    end

    // interrupt state; prev starts at the internal ready levels
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= '0;
            flag_q <= '0;
            stat_prev_q <= ssir_pkg::STATUS_RST;
            rd_valid_q <= 1'b0;
        end else begin
            en_q <= en_d;
            flag_q <= flag_d;
            stat_prev_q <= status_now;
            rd_valid_q <= rd_valid_d;
        end
    end

    // oscillator controls take effect at once, no crossing needed
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_q <= '0;
        end else if (wcom) begin
            if (a_crystal_osc_ctrl) osc_q.crystal_osc <= i_pwdata[15:0] & ssir_pkg::MASK16;
            if (a_x32k) osc_q.crystal_32k <= i_pwdata[15:0] & ssir_pkg::MASK16;
            if (a_i32k) osc_q.internal_32k <= i_pwdata;
            if (a_ulp) osc_q.ultralow_32k <= i_pwdata[7:0] & ssir_pkg::MASK8;
            if (a_i8m) osc_q.internal_8m <= i_pwdata;
        end
    end

    // loop configuration; only written when loop ready
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fll_q <= '0;
        end else if (fll_wr_ok) begin
            if (a_fctl) fll_q.control <= i_pwdata[15:0];
            if (a_fval) fll_q.value <= i_pwdata;
            if (a_fmul) fll_q.multiplier <= i_pwdata;
        end
    end

    // brown-out prescaler controls; commit only after any sync drains
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bod_q.io_ctrl <= ssir_pkg::CTRL_RST;
            bod_q.core_ctrl <= ssir_pkg::CTRL_RST;
        end else if (wcom) begin
            if (a_bio) bod_q.io_ctrl <= i_pwdata;
            if (a_bcore) bod_q.core_ctrl <= i_pwdata;
        end
    end

    // outputs to the clock generators
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_osc_cfg <= '0;
            o_fll_cfg <= '0;
            o_bod_cfg <= '0;
        end else begin
            o_osc_cfg <= osc_q;
            o_fll_cfg <= fll_q;
            o_bod_cfg <= bod_q;
        end
    end
endmodule

// ---- tb/ssir_chk.sv ----
`timescale 1ns/1ps
module ssir_chk #(
    parameter int SYNC_CYCLES = 6
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire logic o_irq,
    input wire ssir_pkg::ssir_fll_cfg_t o_fll_cfg,
    input wire ssir_pkg::ssir_bod_cfg_t o_bod_cfg
);
    logic rd_bod;
    logic wr_all;

    // brown-out reads and full-mask writes, the causes watched below
    assign rd_bod = !i_pwrite && (i_paddr == 8'h34 || i_paddr == 8'h38);
    assign wr_all = o_pready && i_psel && i_pwrite && i_pwdata == 32'h0003CFFF;

    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);

    // ----
    // bus answer
    // ----
    a_ready_one_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held past one cycle");
    a_rdata_idle_zero: assert property (!o_pready |-> o_prdata == 32'h00000000)
        else $error("read data not zero outside ready");
    a_access_completes: assert property ($rose(i_penable) |-> ##[1:40] o_pready)
        else $error("access never answered");
    a_unmapped_error: assert property ($rose(i_penable) && i_paddr > 8'h38
        |=> o_pready && o_pslverr)
        else $error("unmapped access not refused");
    a_bod_read_stalls: assert property ($rose(i_penable) && rd_bod |=> !o_pready [*2])
        else $error("brown-out read answered without sync");

    // ----
    // interrupt and configuration
    // ----
    a_enclr_drops_irq: assert property (wr_all && i_paddr == 8'h00 |-> ##[1:2] !o_irq)
        else $error("irq stays after all enables cleared");
    a_flagclr_drops_irq: assert property (wr_all && i_paddr == 8'h08 |-> ##[1:2] !o_irq)
        else $error("irq stays after all flags cleared");
    a_fll_by_write: assert property (!$stable(o_fll_cfg)
        |-> $past(i_psel && i_pwrite) || $past(i_psel && i_pwrite, 2))
        else $error("loop config moved without a write");
    a_bod_by_write: assert property (!$stable(o_bod_cfg)
        |-> $past(i_psel && i_pwrite) || $past(i_psel && i_pwrite, 2))
        else $error("brown-out config moved without a write");
    a_irq_held_level: assert property ($fell(o_irq) |-> o_pready && i_pwrite)
        else $error("irq dropped without a clearing write");

    c_bod_read: cover property ($rose(i_penable) && rd_bod);
    c_refused: cover property (o_pslverr);
    c_irq: cover property (o_irq);
endmodule

bind ssir_top ssir_chk #(.SYNC_CYCLES(SYNC_CYCLES)) i_chk (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .o_irq(o_irq), .o_fll_cfg(o_fll_cfg),
    .o_bod_cfg(o_bod_cfg)
);

// ---- tb/ssir_cpu_model.sv ----
`timescale 1ns/1ps
module ssir_cpu_model (
    input wire logic i_core_clk,
    input wire logic i_pready,
    input wire logic [31:0] i_prdata,
    input wire logic i_pslverr,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'hFF;
        o_pwdata = 32'h00000000;
    end

    // setup, access, hold until ready; released lines show inverted data
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output int n);
        n = 0;
        @(posedge i_core_clk);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= wd;
        @(posedge i_core_clk);
        o_penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (i_pready !== 1'b1 && n < 100);
        rd = i_prdata;
        err = i_pslverr;
        if (i_pready !== 1'b1) n = -1;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~a;
        o_pwdata <= ~wd;
    endtask

    // poll status until one bit reads one, bounded
    task automatic wait_status(input int b, output int n);
        logic [31:0] d;
        logic e;
        int k;
        for (n = 0; n < 60; n++) begin
            xfer(1'b0, 8'h0C, 32'h00000000, d, e, k);
            if (d[b] === 1'b1) break;
        end
    endtask

    // loop writes only once the loop is ready
    task automatic loop_wr(input logic [7:0] a, input logic [31:0] wd, output int n);
        logic [31:0] d;
        logic e;
        wait_status(ssir_pkg::BIT_LOOP_READY, n);
        xfer(1'b1, a, wd, d, e, n);
    endtask

    // requested loop read: ask, wait for ready, then read
    task automatic loop_rd(input logic [7:0] a, output logic [31:0] d, output int n);
        logic e;
        xfer(1'b1, 8'h30, 32'h00000080, d, e, n);
        wait_status(ssir_pkg::BIT_LOOP_READY, n);
        xfer(1'b0, a, 32'h00000000, d, e, n);
    endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
    localparam int SYNC = 8;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, last_d;
    logic [17:0] raw;
    int last_n, error_cnt, total_checks, k;
    ssir_pkg::ssir_osc_cfg_t osc;
    ssir_pkg::ssir_fll_cfg_t fll;
    ssir_pkg::ssir_bod_cfg_t bod;

    always #50 clk = ~clk;

    ssir_top #(.SYNC_CYCLES(SYNC)) i_dut (
        .i_core_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_raw_status(raw),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_irq(irq),
        .o_osc_cfg(osc), .o_fll_cfg(fll), .o_bod_cfg(bod)
    );

    ssir_cpu_model i_cpu (
        .i_core_clk(clk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr),
        .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
        .o_pwdata(pwdata)
    );

    // ----
    // helpers
    // ----
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    // a bounded wait that ran out ends the run at once
    task automatic hang(input logic bad);
        if (bad) begin
            error_cnt++;
            $display("unexpected at %0t: no answer", $time);
            wrap_up();
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_cpu.xfer(w, a, d, last_d, last_err, last_n);
        hang(last_n < 0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h00000000);
        chk(last_d, e);
    endtask

    task automatic poll(input int b);
        i_cpu.wait_status(b, k);
        hang(k >= 60);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----
    // sequence
    // ----
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        raw = 18'h00000;
        error_cnt = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        // reset state, unmapped offset, narrow register
        rd(8'h0C, 32'h00004810);
        rd(8'h08, 32'h00000000);
        rd(8'h3C, 32'h00000000);
        chk({31'h0, last_err}, 32'h00000001);
        acc(1'b1, 8'h10, 32'hFFFFFFFF);
        rd(8'h10, 32'h0000FFFF);
        chk({16'h0, osc.crystal_osc}, 32'h0000FFFF);
        // one source: raise, mask, re-enable, clear
        acc(1'b1, 8'h04, 32'h00000001);
        raw <= 18'h00001;
        repeat (4) @(posedge clk);
        chk({31'h0, irq}, 32'h00000001);
        rd(8'h08, 32'h00000001);
        acc(1'b1, 8'h08, 32'h00000000);
        rd(8'h08, 32'h00000001);
        acc(1'b1, 8'h00, 32'h0003CFFF);
        rd(8'h04, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        acc(1'b1, 8'h04, 32'h00000001);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h00000001);
        acc(1'b1, 8'h08, 32'h0003CFFF);
        rd(8'h08, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        acc(1'b1, 8'h00, 32'h0003CFFF);
        // loop: write refused during a sync, ready edge, reads
        i_cpu.loop_wr(8'h24, 32'h00000002, last_n);
        poll(ssir_pkg::BIT_LOOP_READY);
        acc(1'b1, 8'h04, 32'h00000010);
        acc(1'b1, 8'h08, 32'h0003CFFF);
        acc(1'b1, 8'h30, 32'h00000080);
        acc(1'b1, 8'h2C, 32'h0000ABCD);
        @(posedge clk);
        chk(fll.multiplier, 32'h00000000);
        chk({16'h0, fll.control}, 32'h00000002);
        poll(ssir_pkg::BIT_LOOP_READY);
        rd(8'h08, 32'h00000010);
        i_cpu.loop_rd(8'h2C, last_d, last_n);
        chk(last_d, 32'h00000000);
        chk(32'(last_n), 32'h00000002);
        i_cpu.loop_wr(8'h2C, 32'h0000ABCD, last_n);
        repeat (2) @(posedge clk);
        chk(fll.multiplier, 32'h0000ABCD);
        rd(8'h2C, 32'h0000ABCD);
        chk(32'(last_n > 2), 32'h00000001);
        i_cpu.loop_wr(8'h24, 32'h00000000, last_n);
        hang(last_n < 0);
        // read while the disabling write still syncs: no valid copy, yet no stall
        acc(1'b0, 8'h28, 32'h00000000);
        chk(32'(last_n), 32'h00000002);
        // brown-out: queued write, stalled read, ready flags
        acc(1'b1, 8'h04, 32'h00004800);
        acc(1'b1, 8'h34, 32'h00000A05);
        acc(1'b0, 8'h0C, 32'h00000000);
        chk({31'h0, last_d[11]}, 32'h00000000);
        acc(1'b1, 8'h38, 32'h00000B06);
        chk(32'(last_n > 2), 32'h00000001);
        @(posedge clk);
        chk(bod.io_ctrl, 32'h00000A05);
        chk(bod.core_ctrl, 32'h00000B06);
        rd(8'h38, 32'h00000B06);
        chk(32'(last_n > 2), 32'h00000001);
        poll(ssir_pkg::BIT_IO_BOD_SYNC_READY);
        poll(ssir_pkg::BIT_CORE_BOD_SYNC_READY);
        // an idle brown-out read runs a full sync of its own
        rd(8'h34, 32'h00000A05);
        chk(32'(last_n > SYNC), 32'h00000001);
        acc(1'b0, 8'h08, 32'h00000000);
        chk(last_d & 32'h00004800, 32'h00004800);
        chk({31'h0, irq}, 32'h00000001);
        wrap_up();
    end
endmodule
